/* core/serial_modem_flow_control.sv */
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module serial_modem_flow_control
    import smfc_pkg::*;
#(
    parameter longint BusyTimeoutCycles = BUSY_TIMEOUT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        dsrIn,
    input  wire logic        running,
    input  wire logic        userMode,
    input  wire logic        scanEnd,
    input  wire logic        rxReady,
    input  wire logic        txActive,
    output logic             dtrOut,
    output logic             rtsOut,
    output logic             txEnable,
    output logic             rxEnable,
    output logic             txAbort,
    output logic             txDone
);
    // Port one is not built here at all

    // The busy counter is 32 bits wide and needs at least two counts
    if (BusyTimeoutCycles < 2 || BusyTimeoutCycles > 64'hffffffff) begin : gLimitCheck
        $error("BusyTimeoutCycles out of range");
    end

    // Ready-input option codes
    localparam logic [15:0] READY_BOTH_ON  = 16'h0001;
    localparam logic [15:0] READY_BOTH_OFF = 16'h0002;
    localparam logic [15:0] READY_SEND_ON  = 16'h0003;
    localparam logic [15:0] READY_SEND_OFF = 16'h0004;

    // Terminal-ready option codes
    localparam logic [15:0] TERM_HELD_OFF  = 16'h0001;
    localparam logic [15:0] TERM_RX_FOLLOW = 16'h0002;

    typedef struct packed {
        // DSR synchroniser
        logic        dsrMeta;
        logic        dsrSync;
        // Software-visible registers
        logic [15:0] readyOpt;
        logic [15:0] termOpt;
        logic [15:0] lineStatus;
        logic [15:0] txStatus;
        // Busy-off duration
        logic [31:0] busyCnt;
        // Bus answer
        logic [31:0] rdata;
        logic        ack;
        // Line and transmit outputs
        logic        dtr;
        logic        rts;
        logic        txEn;
        logic        rxEn;
        logic        abort;
        logic        done;
    } smfc_state_t;

    smfc_state_t st_q;
    smfc_state_t st_d;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] merged;
        merged = old;
        if (be[0]) begin
            merged[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merged[15:8] = wd[15:8];
        end
        return merged;
    endfunction

    // Send permission while running in user mode
    function automatic logic sendAllowed(
        input logic [15:0] opt,
        input logic        dsrOn
    );
        logic allowed;
        unique case (opt)
            READY_BOTH_ON:  allowed = dsrOn;
            READY_BOTH_OFF: allowed = !dsrOn;
            READY_SEND_ON:  allowed = dsrOn;
            READY_SEND_OFF: allowed = !dsrOn;
            default:        allowed = 1'b1;
        endcase
        return allowed;
    endfunction

    // Receive permission; busy control options leave reception open
    function automatic logic receiveAllowed(
        input logic [15:0] opt,
        input logic        dsrOn
    );
        logic allowed;
        unique case (opt)
            READY_BOTH_ON:  allowed = dsrOn;
            READY_BOTH_OFF: allowed = !dsrOn;
            default:        allowed = 1'b1;
        endcase
        return allowed;
    endfunction

    // Terminal-ready level while running in user mode
    function automatic logic dtrLevel(
        input logic [15:0] opt,
        input logic        rxOpen,
        input logic        rxAble
    );
        logic level;
        unique case (opt)
            TERM_HELD_OFF:  level = 1'b0;
            TERM_RX_FOLLOW: level = rxOpen && rxAble;
            default:        level = 1'b1;
        endcase
        return level;
    endfunction

    // Register read mux; unmapped offsets read as zero
    function automatic logic [31:0] readSelect(
        input logic [3:0]  addr,
        input logic [15:0] lineStatus,
        input logic [15:0] readyOpt,
        input logic [15:0] termOpt,
        input logic [15:0] txStatus
    );
        logic [31:0] value;
        unique case (addr)
            OFS_LINE_STATUS: value = {16'h0, lineStatus};
            OFS_READY_OPT:   value = {16'h0, readyOpt};
            OFS_TERM_OPT:    value = {16'h0, termOpt};
            OFS_TX_STATUS:   value = {16'h0, txStatus};
            default:         value = 32'h0;
        endcase
        return value;
    endfunction

    // Status word: DSR in bit 1, DTR in bit 0
    function automatic logic [15:0] lineWord(
        input logic dsrOn,
        input logic dtrOn
    );
        logic [15:0] word;
        word = 16'h0;
        word[LS_DSR_BIT] = dsrOn;
        word[LS_DTR_BIT] = dtrOn;
        return word;
    endfunction

    // Transmit status after a busy timeout
    function automatic logic [15:0] timeoutStatus();
        logic [15:0] word;
        word = 16'h0;
        word[3:0] = ERR_BUSY_TIMEOUT;
        word[TS_DONE_BIT] = 1'b1;
        return word;
    endfunction

    logic        txGate;
    logic        rxGate;
    logic        dtrNext;
    logic        busyHold;
    logic        busyTimeout;
    logic        busRequest;
    logic        writeCommit;
    logic        ackNext;
    logic [31:0] rdataNext;
    logic [15:0] readyOptNext;
    logic [15:0] termOptNext;
    logic        txStatusClear;

    // Send and receive gates
    always_comb begin
        txGate = 1'b1;
        rxGate = 1'b1;
        if (userMode) begin
            if (running) begin
                txGate = sendAllowed(st_q.readyOpt, st_q.dsrSync);
                rxGate = receiveAllowed(st_q.readyOpt, st_q.dsrSync);
            end else begin
                txGate = 1'b0;
                rxGate = 1'b0;
            end
        end
    end

    // Terminal-ready level; maintenance mode holds it on
    always_comb begin
        if (!userMode) begin
            dtrNext = 1'b1;
        end else if (!running) begin
            dtrNext = 1'b0;
        end else begin
            dtrNext = dtrLevel(st_q.termOpt, rxGate, rxReady);
        end
    end

    // Sending held off by a busy terminal under busy control
    always_comb begin
        busyHold = userMode && running && (st_q.readyOpt == READY_SEND_ON)
                   && txActive && !st_q.dsrSync;
        busyTimeout = busyHold && (st_q.busyCnt >= 32'(BusyTimeoutCycles - 1));
    end

    // Bus requests
    always_comb begin
        busRequest = avs_read || avs_write;
        writeCommit = avs_write && st_q.ack;
    end

    // One wait state, then a single answer cycle; read data captured with it
    always_comb begin
        ackNext = busRequest && !st_q.ack;
        rdataNext = st_q.rdata;
        if (ackNext) begin
            if (avs_read) begin
                rdataNext = readSelect(avs_address, st_q.lineStatus, st_q.readyOpt,
                                       st_q.termOpt, st_q.txStatus);
            end else begin
                rdataNext = 32'h0;
            end
        end
    end

    // A write lands at the edge where waitrequest is sampled low
    always_comb begin
        readyOptNext = st_q.readyOpt;
        termOptNext = st_q.termOpt;
        txStatusClear = 1'b0;
        if (writeCommit) begin
            unique case (avs_address)
                OFS_READY_OPT: begin
                    readyOptNext = merge16(st_q.readyOpt, avs_writedata, avs_byteenable);
                end
                OFS_TERM_OPT: begin
                    termOptNext = merge16(st_q.termOpt, avs_writedata, avs_byteenable);
                end
                OFS_TX_STATUS: begin
                    txStatusClear = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Next state of the whole block
    always_comb begin
        st_d = st_q;
        st_d.dsrMeta = dsrIn;
        st_d.dsrSync = st_q.dsrMeta;
        st_d.rts = 1'b1;
        st_d.txEn = txGate && !st_q.abort;
        st_d.rxEn = rxGate;
        st_d.dtr = dtrNext;
        st_d.abort = 1'b0;
        st_d.done = 1'b0;

        // Busy-off duration counter
        if (!busyHold) begin
            st_d.busyCnt = 32'h0;
        end else if (!busyTimeout) begin
            st_d.busyCnt = st_q.busyCnt + 32'h1;
        end

        st_d.ack = ackNext;
        st_d.rdata = rdataNext;
        st_d.readyOpt = readyOptNext;
        st_d.termOpt = termOptNext;
        if (txStatusClear) begin
            st_d.txStatus = 16'h0;
        end

        // Status word is sampled only at end of scan
        if (scanEnd) begin
            st_d.lineStatus = lineWord(st_q.dsrSync, st_q.dtr);
        end

        // Timeout set wins over a software clear in the same cycle
        if (busyTimeout) begin
            st_d.abort = 1'b1;
            st_d.done = 1'b1;
            st_d.txEn = 1'b0;
            st_d.busyCnt = 32'h0;
            st_d.txStatus = timeoutStatus();
        end
    end

    // Synchronous reset; options return to their defaults
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.readyOpt <= READY_OPT_RESET;
            st_q.termOpt <= TERM_OPT_RESET;
            st_q.rts <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Registered outputs
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = !st_q.ack;
    assign dtrOut = st_q.dtr;
    assign rtsOut = st_q.rts;
    assign txEnable = st_q.txEn;
    assign rxEnable = st_q.rxEn;
    assign txAbort = st_q.abort;
    assign txDone = st_q.done;
endmodule // serial_modem_flow_control
`default_nettype wire

/* core/smfc_pkg.sv */
package smfc_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_LINE_STATUS   = 4'h0;
    localparam logic [3:0] OFS_READY_OPT     = 4'h4;
    localparam logic [3:0] OFS_TERM_OPT      = 4'h8;
    localparam logic [3:0] OFS_TX_STATUS     = 4'hc;
    localparam logic [15:0] READY_OPT_RESET  = 16'h0000;
    localparam logic [15:0] TERM_OPT_RESET   = 16'h0000;
    // Line status field positions
    localparam int LS_DTR_BIT = 0;
    localparam int LS_DSR_BIT = 1;
    // Transmit status fields
    localparam logic [3:0] ERR_BUSY_TIMEOUT  = 4'h2;
    localparam int TS_DONE_BIT = 4;
    // Busy timeout
    localparam longint BUSY_TIMEOUT_MS = 5000;
    localparam longint CLOCK_HZ        = 125000000;
    localparam longint BUSY_TIMEOUT_CYCLES = (BUSY_TIMEOUT_MS * CLOCK_HZ) / 1000;
endpackage

/* verif/serial_modem_flow_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_modem_flow_control_tb;
    import smfc_pkg::*;
    logic        clock = 0, reset_n = 0, avs_read = 0, avs_write = 0, busy = 0, waitReq;
    logic        running = 0, userMode = 1, scanEnd = 0, rxReady = 1, txActive = 0;
    logic        dsr, dtrOut, rtsOut, txEnable, rxEnable, txAbort, txDone;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, readData, rd;
    int          fails = 0, checked = 0, cycles = 0;
    always #4 clock = ~clock;
    smfc_terminal term_u (.clock(clock), .busy(busy), .dsrLine(dsr));
    serial_modem_flow_control #(.BusyTimeoutCycles(20)) dut_u (
        .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(readData), .avs_waitrequest(waitReq), .dsrIn(dsr), .running(running),
        .userMode(userMode), .scanEnd(scanEnd), .rxReady(rxReady), .txActive(txActive),
        .dtrOut(dtrOut), .rtsOut(rtsOut), .txEnable(txEnable), .rxEnable(rxEnable),
        .txAbort(txAbort), .txDone(txDone));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (waitReq !== 1'b0);
        rd = readData;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic scan();
        repeat (5) @(posedge clock);
        scanEnd <= 1'b1;
        @(posedge clock);
        scanEnd <= 1'b0;
    endtask
    function automatic logic gate(input int o, input int d, input bit tx);
        if (o == 1 || (o == 3 && tx)) return d[0];
        if (o == 2 || (o == 4 && tx)) return !d[0];
        return 1'b1;
    endfunction
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        acc(0, OFS_READY_OPT, 0);
        chk("ready opt", rd, {16'h0, READY_OPT_RESET});
        chk("rts", rtsOut, 1'b1);
        acc(0, OFS_TERM_OPT, 0);
        chk("term opt", rd, {16'h0, TERM_OPT_RESET});
        acc(0, 4'h2, 0);
        chk("unmapped", rd, 32'h0);
        running <= 1'b1;
        acc(1, OFS_LINE_STATUS, 16'h0);
        scan();
        acc(0, OFS_LINE_STATUS, 0);
        chk("status", rd, 32'h3);
        busy <= 1'b1;
        repeat (5) @(posedge clock);
        acc(0, OFS_LINE_STATUS, 0);
        chk("status held", rd, 32'h3);
        scan();
        acc(0, OFS_LINE_STATUS, 0);
        chk("status dtr only", rd, 32'h1);
        for (int o = 0; o < 6; o++) begin
            for (int d = 0; d < 2; d++) begin
                busy <= !d[0];
                acc(1, OFS_READY_OPT, o[15:0]);
                repeat (5) @(posedge clock);
                chk("tx gate", txEnable, gate(o, d, 1));
                chk("rx gate", rxEnable, gate(o, d, 0));
            end
        end
        for (int t = 0; t < 6; t++) begin
            rxReady <= t[0];
            acc(1, OFS_TERM_OPT, t[15:0]);
            repeat (5) @(posedge clock);
            chk("dtr", dtrOut, t != 1 && (t != 2 || rxReady));
        end
        acc(1, OFS_READY_OPT, 16'h1);
        acc(1, OFS_TERM_OPT, 16'h2);
        rxReady <= 1'b1;
        busy <= 1'b1;
        repeat (5) @(posedge clock);
        chk("dtr rx closed", dtrOut, 1'b0);
        busy <= 1'b0;
        repeat (5) @(posedge clock);
        chk("dtr rx open", dtrOut, 1'b1);
        running <= 1'b0;
        repeat (5) @(posedge clock);
        chk("dtr stopped", dtrOut, 1'b0);
        chk("tx stopped", txEnable, 1'b0);
        userMode <= 1'b0;
        repeat (5) @(posedge clock);
        chk("dtr maint", dtrOut, 1'b1);
        chk("rx maint", rxEnable, 1'b1);
        userMode <= 1'b1;
        running <= 1'b1;
        acc(1, OFS_READY_OPT, 16'h3);
        busy <= 1'b1;
        txActive <= 1'b1;
        for (int i = 0; i < 60 && txAbort !== 1'b1; i++) @(posedge clock);
        chk("abort pulse", txAbort, 1'b1);
        chk("done with abort", txDone, 1'b1);
        txActive <= 1'b0;
        acc(0, OFS_TX_STATUS, 0);
        chk("error code", rd[3:0], ERR_BUSY_TIMEOUT);
        chk("done bit", rd[TS_DONE_BIT], 1'b1);
        acc(1, OFS_TX_STATUS, 0);
        acc(0, OFS_TX_STATUS, 0);
        chk("status cleared", rd, 32'h0);
        complete_run();
    end
endmodule // serial_modem_flow_control_tb
`default_nettype wire

/* verif/smfc_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module smfc_sva (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic running,
    input wire logic userMode,
    input wire logic txActive,
    input wire logic dtrOut,
    input wire logic rtsOut,
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic txAbort,
    input wire logic txDone
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_RTS_ON: assert property (rtsOut) else $error("rts dropped");
    AST_STOP_GATE: assert property ((userMode && !running) [*2]
        |-> !txEnable && !rxEnable) else $error("gates open while stopped");
    AST_STOP_DTR: assert property ((userMode && !running) [*2]
        |-> !dtrOut) else $error("dtr on while stopped");
    AST_MAINT: assert property (!userMode [*2]
        |-> dtrOut && txEnable && rxEnable) else $error("maintenance mode gated");
    AST_DONE_ABORT: assert property (txAbort |-> txDone) else $error("no done");
    AST_ABORT_PULSE: assert property (txAbort |=> !txAbort) else $error("long abort");
    AST_ABORT_CAUSE: assert property (txAbort |-> $past(txActive))
        else $error("abort without send");
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("bus not answered");
    AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held");
    cover property (txAbort);
    cover property (!userMode [*2]);
    cover property (avs_read && !avs_waitrequest);
endmodule // smfc_sva
bind serial_modem_flow_control smfc_sva chk_u (.clock(clock), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .running(running), .userMode(userMode), .txActive(txActive), .dtrOut(dtrOut),
    .rtsOut(rtsOut), .txEnable(txEnable), .rxEnable(rxEnable), .txAbort(txAbort),
    .txDone(txDone));
`default_nettype wire

/* verif/smfc_terminal.sv */
`timescale 1ns/1ps
`default_nettype none
module smfc_terminal (
    input  wire logic clock,
    input  wire logic busy,
    output logic      dsrLine
);
    // A printer that is free to take data holds DSR on
    always_ff @(posedge clock) dsrLine <= !busy;
endmodule // smfc_terminal
`default_nettype wire
